// ---- core/ciomj_map.vh ----
// constants for the increment, or, move and jump execution core
`ifndef CIOMJ_MAP_VH
`define CIOMJ_MAP_VH

// instruction word layout
`define CIOMJ_IW_WIDTH 14
`define CIOMJ_PC_WIDTH 13
`define CIOMJ_FA_WIDTH 7
`define CIOMJ_DW_WIDTH 8
`define CIOMJ_D_BIT 7
`define CIOMJ_OP6_HI 13
`define CIOMJ_OP6_LO 8
`define CIOMJ_OP3_LO 11
`define CIOMJ_JMP_HI 10

// opcode encodings, six-bit major field
`define CIOMJ_OP_INC_SKIP 6'h0f
`define CIOMJ_OP_INC 6'h0a
`define CIOMJ_OP_OR_REG 6'h04
`define CIOMJ_OP_COPY 6'h08
`define CIOMJ_OP_OR_LIT 6'h38
// three-bit major field of the jump
`define CIOMJ_OP3_JUMP 3'h5

// upper program counter latch bits feeding pc<12:11>
`define CIOMJ_UPL_HI 4
`define CIOMJ_UPL_LO 3

// reset values
`define CIOMJ_PC_RST 13'h0000
`define CIOMJ_ACC_RST 8'h00

// instruction cycle phases, four clocks per cycle
`define CIOMJ_PH_FETCH 2'h0
`define CIOMJ_PH_READ 2'h1
`define CIOMJ_PH_EXEC 2'h2
`define CIOMJ_PH_ADV 2'h3
`define CIOMJ_CLK_PER_TCY 4
// cycles taken by a skip that hits or by a jump
`define CIOMJ_TCY_LONG 2

`endif

// ---- core/ciomj_core.v ----
// execution core for increment, or, move, jump and idle instructions
`timescale 1ns/1ns
`default_nettype none
`include "ciomj_map.vh"
module ciomj_core (
   // clock and reset
   input wire I_CLK_SYS,
   input wire I_RESET,
   // program memory
   input wire [`CIOMJ_IW_WIDTH-1:0] I_INSTR,
   output reg [`CIOMJ_PC_WIDTH-1:0] O_PC,
   // file register port
   input wire [`CIOMJ_DW_WIDTH-1:0] I_FR_RDATA,
   output reg [`CIOMJ_FA_WIDTH-1:0] O_FR_ADDR,
   output reg O_FR_WE,
   output reg [`CIOMJ_DW_WIDTH-1:0] O_FR_WDATA,
   // upper program counter latch
   input wire [4:0] I_UPPER_PC_LATCH,
   // core state
   output reg [`CIOMJ_DW_WIDTH-1:0] O_ACC,
   output reg O_NULL_FLAG,
   output reg O_BUBBLE
);

////////////////////////////////////////////////////////////////////////////////
// state

reg [1:0] phase;
reg [`CIOMJ_IW_WIDTH-1:0] ir;
reg [`CIOMJ_DW_WIDTH-1:0] opnd;
reg bubble_adv;

////////////////////////////////////////////////////////////////////////////////
// decode and result

wire [5:0] op6 = ir[`CIOMJ_OP6_HI:`CIOMJ_OP6_LO];
wire dest_f = ir[`CIOMJ_D_BIT];
reg [`CIOMJ_DW_WIDTH-1:0] res;
reg to_acc;
reg to_reg;
reg upd_z;
reg is_skip;
reg is_jump;

// operation select; anything unlisted runs as idle
always @* begin
   res = opnd;
   to_acc = 1'b0;
   to_reg = 1'b0;
   upd_z = 1'b0;
   is_skip = 1'b0;
   is_jump = 1'b0;
   if (ir[`CIOMJ_OP6_HI:`CIOMJ_OP3_LO] == `CIOMJ_OP3_JUMP) begin
      is_jump = 1'b1;
   end else begin
      case (op6)
         `CIOMJ_OP_INC_SKIP: begin
            res = opnd + 8'h01;
            to_acc = ~dest_f;
            to_reg = dest_f;
            is_skip = (res == 8'h00);
         end
         `CIOMJ_OP_INC: begin
            res = opnd + 8'h01;
            to_acc = ~dest_f;
            to_reg = dest_f;
            upd_z = 1'b1;
         end
         `CIOMJ_OP_OR_REG: begin
            res = O_ACC | opnd;
            to_acc = ~dest_f;
            to_reg = dest_f;
            upd_z = 1'b1;
         end
         `CIOMJ_OP_COPY: begin
            res = opnd;
            to_acc = ~dest_f;
            to_reg = dest_f;
            upd_z = 1'b1;
         end
         `CIOMJ_OP_OR_LIT: begin
            res = O_ACC | ir[`CIOMJ_DW_WIDTH-1:0];
            to_acc = 1'b1;
            upd_z = 1'b1;
         end
         default: begin
            res = opnd;
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////////
// phase decode
//
// four clocks make one instruction cycle; the phase counter runs free
// from reset release, so instruction boundaries are fixed by reset alone

// one flag per phase
wire in_fetch = (phase == `CIOMJ_PH_FETCH);
wire in_read = (phase == `CIOMJ_PH_READ);
wire in_exec = (phase == `CIOMJ_PH_EXEC);
wire in_adv = (phase == `CIOMJ_PH_ADV);

// a filler cycle commits nothing and ignores its fetched word
wire commit = in_exec & ~O_BUBBLE;
wire zero_res = (res == 8'h00);
// program counter candidates
wire [`CIOMJ_PC_WIDTH-1:0] pc_inc = O_PC + 13'h0001;
wire [`CIOMJ_PC_WIDTH-1:0] jump_target = {I_UPPER_PC_LATCH[`CIOMJ_UPL_HI:`CIOMJ_UPL_LO],
   ir[`CIOMJ_JMP_HI:0]};

////////////////////////////////////////////////////////////////////////////////
// next values

reg [1:0] next_phase;
reg [`CIOMJ_IW_WIDTH-1:0] next_ir;
reg [`CIOMJ_FA_WIDTH-1:0] next_addr;
reg [`CIOMJ_DW_WIDTH-1:0] next_opnd;
reg [`CIOMJ_DW_WIDTH-1:0] next_acc;
reg next_flag;
reg next_we;
reg [`CIOMJ_DW_WIDTH-1:0] next_wdata;
reg [`CIOMJ_PC_WIDTH-1:0] next_pc;
reg next_bubble;
reg next_bubble_adv;

// phase counter wraps after the last phase
always @* begin
   next_phase = phase + 2'h1;
end

// fetch latches the word and presents its register address
// operand is taken one phase later, once the address has settled
always @* begin
   next_ir = ir;
   next_addr = O_FR_ADDR;
   next_opnd = opnd;
   if (in_fetch) begin
      next_ir = I_INSTR;
      next_addr = I_INSTR[`CIOMJ_FA_WIDTH-1:0];
   end
   if (in_read) begin
      next_opnd = I_FR_RDATA;
   end
end

// result commit to accumulator, zero flag and file register
// the write strobe stands through the last phase only, so the
// store lands before the next instruction reads its operand
always @* begin
   next_acc = O_ACC;
   next_flag = O_NULL_FLAG;
   next_we = O_FR_WE;
   next_wdata = O_FR_WDATA;
   if (commit) begin
      if (to_acc) begin
         next_acc = res;
      end
      if (to_reg) begin
         next_we = 1'b1;
         next_wdata = res;
      end
      if (upd_z) begin
         next_flag = zero_res;
      end
   end
   // strobe drops at the end of the cycle
   if (in_adv) begin
      next_we = 1'b0;
   end
end

// program counter and filler cycle control
// a jump moves the pc now and holds it through the filler;
// a taken skip steps now and again at the end of the filler
always @* begin
   next_pc = O_PC;
   next_bubble = O_BUBBLE;
   next_bubble_adv = bubble_adv;
   if (in_adv) begin
      if (O_BUBBLE) begin
         next_bubble = 1'b0;
         if (bubble_adv) begin
            next_pc = pc_inc;
         end
      end else if (is_jump) begin
         next_pc = jump_target;
         next_bubble = 1'b1;
         next_bubble_adv = 1'b0;
      end else if (is_skip) begin
         next_pc = pc_inc;
         next_bubble = 1'b1;
         next_bubble_adv = 1'b1;
      end else begin
         next_pc = pc_inc;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// registers

// phase counter
always @(posedge I_CLK_SYS) begin
   if (I_RESET) begin
      phase <= `CIOMJ_PH_FETCH;
   end else begin
      phase <= next_phase;
   end
end

// instruction latch and file register address
always @(posedge I_CLK_SYS) begin
   if (I_RESET) begin
      ir <= {`CIOMJ_IW_WIDTH{1'b0}};
      O_FR_ADDR <= 7'h00;
   end else begin
      ir <= next_ir;
      O_FR_ADDR <= next_addr;
   end
end

// operand latch
always @(posedge I_CLK_SYS) begin
   if (I_RESET) begin
      opnd <= 8'h00;
   end else begin
      opnd <= next_opnd;
   end
end

// accumulator
always @(posedge I_CLK_SYS) begin
   if (I_RESET) begin
      O_ACC <= `CIOMJ_ACC_RST;
   end else begin
      O_ACC <= next_acc;
   end
end

// zero flag
always @(posedge I_CLK_SYS) begin
   if (I_RESET) begin
      O_NULL_FLAG <= 1'b0;
   end else begin
      O_NULL_FLAG <= next_flag;
   end
end

// file register write port
always @(posedge I_CLK_SYS) begin
   if (I_RESET) begin
      O_FR_WE <= 1'b0;
      O_FR_WDATA <= 8'h00;
   end else begin
      O_FR_WE <= next_we;
      O_FR_WDATA <= next_wdata;
   end
end

// program counter
always @(posedge I_CLK_SYS) begin
   if (I_RESET) begin
      O_PC <= `CIOMJ_PC_RST;
   end else begin
      O_PC <= next_pc;
   end
end

// filler cycle flag and its pending step
always @(posedge I_CLK_SYS) begin
   if (I_RESET) begin
      O_BUBBLE <= 1'b0;
      bubble_adv <= 1'b0;
   end else begin
      O_BUBBLE <= next_bubble;
      bubble_adv <= next_bubble_adv;
   end
end

endmodule // ciomj_core
`default_nettype wire

// ---- bench/ciomj_core_checker.sv ----
// assertion checker for the execution core
`timescale 1ns/1ns
`default_nettype none
module ciomj_chk (
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   // watched ports
   input wire logic [12:0] O_PC,
   input wire logic O_FR_WE,
   input wire logic [7:0] O_FR_WDATA,
   input wire logic [4:0] I_UPPER_PC_LATCH,
   input wire logic [7:0] O_ACC,
   input wire logic O_NULL_FLAG,
   input wire logic O_BUBBLE
);
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RESET);
   property p_we; O_FR_WE |=> !O_FR_WE; endproperty
   a_we: assert property (p_we) else $error("long write");
   property p_bub; $rose(O_BUBBLE) |=> O_BUBBLE[*3] ##1 !O_BUBBLE; endproperty
   a_bub: assert property (p_bub) else $error("bubble length");
   property p_nowb; O_BUBBLE |-> !O_FR_WE; endproperty
   a_nowb: assert property (p_nowb) else $error("bubble write");
   property p_pc; $changed(O_PC) && !$rose(O_BUBBLE) |-> O_PC == $past(O_PC) + 13'h1; endproperty
   a_pc: assert property (p_pc) else $error("pc step");
   property p_wepc; O_FR_WE |=> O_PC == $past(O_PC) + 13'h1; endproperty
   a_wepc: assert property (p_wepc) else $error("pc after write");
   property p_jmp; $rose(O_BUBBLE) && O_PC != $past(O_PC) + 13'h1
      |-> O_PC >> 11 == $past(I_UPPER_PC_LATCH) >> 3; endproperty
   a_jmp: assert property (p_jmp) else $error("jump upper bits");
   property p_acc; $changed(O_ACC) |-> !O_FR_WE && !O_BUBBLE; endproperty
   a_acc: assert property (p_acc) else $error("acc dest");
   property p_nf; $changed(O_NULL_FLAG)
      |-> O_NULL_FLAG == (O_FR_WE ? O_FR_WDATA == 8'h00 : O_ACC == 8'h00); endproperty
   a_nf: assert property (p_nf) else $error("zero flag");
endmodule // ciomj_chk
bind ciomj_core ciomj_chk i_ciomj_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET),
   .O_PC(O_PC), .O_FR_WE(O_FR_WE), .O_FR_WDATA(O_FR_WDATA),
   .I_UPPER_PC_LATCH(I_UPPER_PC_LATCH), .O_ACC(O_ACC), .O_NULL_FLAG(O_NULL_FLAG),
   .O_BUBBLE(O_BUBBLE));
`default_nettype wire

// ---- bench/tb_ciomj_core.sv ----
// self-checking bench for the execution core
`timescale 1ns/1ns
`default_nettype none
module tb_ciomj_core;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] upl = 5'h08;
   logic [13:0] prog [0:8191];
   logic [7:0] fr [0:127];
   logic [13:0] code [0:10] = '{14'h3800, 14'h385a, 14'h0a05, 14'h0486, 14'h0887,
      14'h0f85, 14'h38ff, 14'h0f86, 14'h3801, 14'h0000, 14'h2923};
   wire [12:0] pc;
   wire [6:0] fa;
   wire [7:0] wd, acc;
   wire we, nf, bub;
   int errors = 0;
   int num_checks = 0;
   ciomj_core i_ciomj_core (.I_CLK_SYS(clk), .I_RESET(rst), .I_INSTR(prog[pc]), .O_PC(pc),
      .I_FR_RDATA(fr[fa]), .O_FR_ADDR(fa), .O_FR_WE(we), .O_FR_WDATA(wd),
      .I_UPPER_PC_LATCH(upl), .O_ACC(acc), .O_NULL_FLAG(nf), .O_BUBBLE(bub));
   // clock and file register memory
   initial forever #25 clk = ~clk;
   always @(posedge clk) if (we) fr[fa] <= wd;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %h %h", $time, got, exp);
      end
   endtask
   task automatic run(input int n);
      repeat (4 * n) @(negedge clk);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic t_alu;
      run(1);
      chk(nf, 1'b1);
      run(1);
      chk({acc, 7'h0, nf}, 16'h5a00);
      run(1);
      chk({fr[5], acc, 7'h0, nf}, 24'hff0001);
      run(1);
      chk({fr[6], acc, 7'h0, nf}, 24'h300000);
      run(1);
      chk({fr[7], acc, 7'h0, nf}, 24'h000001);
   endtask
   task automatic t_skip;
      run(2);
      chk({3'h0, pc, fr[5], 7'h0, nf}, 32'h00070001);
      run(1);
      chk({fr[6], 7'h0, nf}, 16'h3101);
      run(1);
      chk({acc, 7'h0, nf}, 16'h0100);
   endtask
   task automatic t_jump;
      run(1);
      chk({3'h0, pc, acc}, 24'h000a01);
      run(1);
      chk({bub, pc}, 14'h2923);
      run(1);
      chk({bub, pc}, 14'h0923);
      run(1);
      chk(acc, 8'h81);
      // copy back into the top register address, strobe seen in the last phase
      repeat (3) @(negedge clk);
      chk({we, fa}, 8'hff);
      chk(wd, 8'h00);
      @(negedge clk);
      chk({fr[127], acc, 7'h0, nf}, 24'h008101);
   endtask
   // program load and main sequence
   initial begin
      foreach (prog[i]) prog[i] = 14'h0000;
      foreach (fr[i]) fr[i] = 8'h00;
      foreach (code[i]) prog[i] = code[i];
      prog[13'h0923] = 14'h3880;
      prog[13'h0924] = 14'h08ff;
      fr[5] = 8'hff;
      fr[6] = 8'h30;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      t_alu;
      t_skip;
      t_jump;
      close_out;
   end
   // watchdog
   initial begin
      #20000;
      errors++;
      close_out;
   end
endmodule // tb_ciomj_core
`default_nettype wire
